//--- inc/vspo_pkg.sv
package vspo_pkg;

  // lane symbol widths with and without fixed-rate-link support
  localparam int unsigned LANE_W_MTC   = 20;
  localparam int unsigned LANE_W_FRL   = 40;
  localparam int unsigned NUM_LANES    = 4;
  localparam int unsigned PIX_W        = 48;
  localparam int unsigned PIX_PER_CLK  = 2;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned CNT_W        = 24;

  // link rates at or below this carry data on three lanes only
  localparam logic [2:0]  FRL_RATE_3LANE_MAX = 3'h2;
  localparam logic [2:0]  FRL_RATE_MAX       = 3'h6;

  // per-lane slice widths used to build one 48-bit pixel
  localparam int unsigned SLICE_3LANE_W = 16;
  localparam int unsigned SLICE_4LANE_W = 12;

  // control bit positions inside the lane 0 symbol
  localparam int unsigned CTL_DE_BIT = 16;
  localparam int unsigned CTL_HS_BIT = 17;
  localparam int unsigned CTL_VS_BIT = 18;

  // frames of agreement to assert, of disagreement to drop timing stability
  localparam int unsigned STABLE_FRAMES   = 3;
  localparam int unsigned UNSTABLE_FRAMES = 2;

  // one pixel slot as it travels through the crossing buffer
  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic             de;
    logic             hs;
    logic             vs;
  } vspo_pix_s;

  localparam int unsigned SLOT_W = $bits(vspo_pix_s);

  // link-side word assembly states
  typedef enum logic [2:0] {
    LK_WAIT = 3'b001,
    LK_FILL = 3'b010,
    LK_HOLD = 3'b100
  } vspo_link_e;

endpackage

//--- logic/vspo_fifo.sv
`timescale 1ns/1ns
module vspo_fifo
  import vspo_pkg::*;
#(
  parameter int unsigned WIDTH = SLOT_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  input  wire logic             wr_clk_i,
  input  wire logic             wr_rst_n_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_clk_i,
  input  wire logic             rd_rst_n_i,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_bin_q;
  logic [AW:0]      wr_gray_q;
  logic [AW:0]      rd_bin_q;
  logic [AW:0]      rd_gray_q;
  logic [AW:0]      rg_s1_q;
  logic [AW:0]      rg_s2_q;
  logic [AW:0]      wg_s1_q;
  logic [AW:0]      wg_s2_q;
  logic [AW:0]      wr_bin_d;
  logic [AW:0]      rd_bin_d;
  logic             push;
  logic             pop;

  // full compares against the read pointer seen through two flops
  assign wr_ready_o = wr_gray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
  assign rd_valid_o = rd_gray_q != wg_s2_q;
  assign push       = wr_valid_i & wr_ready_o;
  assign pop        = rd_valid_o & rd_ready_i;
  assign wr_bin_d   = wr_bin_q + (AW+1)'(push);
  assign rd_bin_d   = rd_bin_q + (AW+1)'(pop);
  assign rd_data_o  = mem[rd_bin_q[AW-1:0]];

  // storage, no reset needed since empty hides stale words
  always_ff @(posedge wr_clk_i)
  begin
    if (push)
      mem[wr_bin_q[AW-1:0]] <= wr_data_i;
  end

  // write pointer, binary and gray kept together
  always_ff @(posedge wr_clk_i)
  begin
    if (!wr_rst_n_i)
    begin
      wr_bin_q  <= '0;
      wr_gray_q <= '0;
    end
    else
    begin
      wr_bin_q  <= wr_bin_d;
      wr_gray_q <= wr_bin_d ^ (wr_bin_d >> 1);
    end
  end

  // read pointer into the write domain
  always_ff @(posedge wr_clk_i)
  begin
    if (!wr_rst_n_i)
    begin
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end
    else
    begin
      rg_s1_q <= rd_gray_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  // read pointer
  always_ff @(posedge rd_clk_i)
  begin
    if (!rd_rst_n_i)
    begin
      rd_bin_q  <= '0;
      rd_gray_q <= '0;
    end
    else
    begin
      rd_bin_q  <= rd_bin_d;
      rd_gray_q <= rd_bin_d ^ (rd_bin_d >> 1);
    end
  end

  // write pointer into the read domain
  always_ff @(posedge rd_clk_i)
  begin
    if (!rd_rst_n_i)
    begin
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end
    else
    begin
      wg_s1_q <= wr_gray_q;
      wg_s2_q <= wg_s1_q;
    end
  end

endmodule // vspo_fifo

//--- logic/vspo_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - pixel clock fully asynchronous; all crossings safe
// - fixed-rate mode rates 3-6 use four lanes
// - rates 1 and 2 use three lanes only
// - N pixels of 48 bits per clock
// - one active-video bit per pixel slot
// - one line and frame sync per slot
// - qualifier marks cycles carrying real pixels
// - qualifier constant when pixel clock equals pixel rate
// - faster pixel clock: qualifier paces exact pixel rate
// - link acquired only after lock, deskew, alignment
// - timing stable after three matching frames
// - timing unstable after two mismatching frames
// - lane 0 carries blue or fixed-rate lane 0
// - lane width 20 or 40; low 20 in MTC
module vspo_top
  import vspo_pkg::*;
#(
  parameter int unsigned N           = PIX_PER_CLK,
  parameter bit          FRL_SUPPORT = 1'b1,
  parameter int unsigned DEPTH       = FIFO_DEPTH,
  parameter int unsigned LANE_W      = FRL_SUPPORT ? LANE_W_FRL : LANE_W_MTC
)(
  input  wire logic                            clock_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            link_speed_clock_i,
  input  wire logic                            link_rst_n_i,
  input  wire logic [NUM_LANES-1:0][LANE_W-1:0] lane_symbols_i,
  input  wire logic                            lanes_aligned_i,
  input  wire logic                            fixed_rate_mode_i,
  input  wire logic [2:0]                      link_rate_i,
  input  wire logic                            pixel_ready_i,
  output logic [N*PIX_W-1:0]                   pixel_data_out_o,
  output logic [N-1:0]                         active_video_flag_o,
  output logic [N-1:0]                         line_sync_out_o,
  output logic [N-1:0]                         frame_sync_out_o,
  output logic                                 pixel_qualifier_o,
  output logic                                 link_acquired_o,
  output logic                                 video_timing_stable_o
);

  localparam int unsigned WORD_W = N * SLOT_W;
  localparam int unsigned SEL_W  = (N > 1) ? $clog2(N) : 1;
  localparam int unsigned CFG_W  = 5;
  localparam logic [SEL_W-1:0] LAST_SLOT = SEL_W'(N - 1);
  localparam logic [1:0]       STABLE_MATCHES = 2'(STABLE_FRAMES - 1);
  localparam logic [1:0]       UNSTABLE_MISSES = 2'(UNSTABLE_FRAMES);
  localparam logic [1:0]       CMP_SEEN = 2'h2;  // starts seen before a whole frame pair exists

  // ---------------- link domain ----------------
  logic [CFG_W-1:0] cfg_s1_q;
  logic [CFG_W-1:0] cfg_s2_q;
  logic             lk_aligned;
  logic             lk_frl;
  logic [2:0]       lk_rate;
  vspo_link_e       lk_state_q;
  vspo_link_e       lk_state_d;
  logic [SEL_W-1:0] slot_q;
  vspo_pix_s        slots_q [N];
  vspo_pix_s        cur_pix;
  logic [WORD_W-1:0] wr_word;
  logic             wr_valid;
  logic             wr_ready;
  logic             take;

  // straps and lock come from outside this clock, so two flops first
  always_ff @(posedge link_speed_clock_i)
  begin
    if (!link_rst_n_i)
    begin
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
    end
    else
    begin
      cfg_s1_q <= {lanes_aligned_i, fixed_rate_mode_i, link_rate_i};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  assign lk_aligned = cfg_s2_q[4];
  assign lk_frl     = cfg_s2_q[3] & FRL_SUPPORT;
  assign lk_rate    = cfg_s2_q[2:0];

  // lane slicing into one pixel; lane 0 always holds the controls
  always_comb
  begin
    cur_pix    = '0;
    cur_pix.de = lane_symbols_i[0][CTL_DE_BIT];
    cur_pix.hs = lane_symbols_i[0][CTL_HS_BIT];
    cur_pix.vs = lane_symbols_i[0][CTL_VS_BIT];
    if (lk_frl && lk_rate > FRL_RATE_3LANE_MAX && lk_rate <= FRL_RATE_MAX)
      cur_pix.data = {lane_symbols_i[3][SLICE_4LANE_W-1:0],
                      lane_symbols_i[2][SLICE_4LANE_W-1:0],
                      lane_symbols_i[1][SLICE_4LANE_W-1:0],
                      lane_symbols_i[0][SLICE_4LANE_W-1:0]};
    else
      cur_pix.data = {lane_symbols_i[2][SLICE_3LANE_W-1:0],
                      lane_symbols_i[1][SLICE_3LANE_W-1:0],
                      lane_symbols_i[0][SLICE_3LANE_W-1:0]};
  end

  // a full word waits in HOLD; a refill in the same cycle is not lost
  assign wr_valid = lk_state_q == LK_HOLD;
  assign take     = (lk_state_q == LK_FILL) || (wr_valid && wr_ready);

  always_comb
  begin
    lk_state_d = lk_state_q;
    case (lk_state_q)
      LK_WAIT:
        if (lk_aligned)
          lk_state_d = LK_FILL;
      LK_FILL:
        if (!lk_aligned)
          lk_state_d = LK_WAIT;
        else if (slot_q == LAST_SLOT)
          lk_state_d = LK_HOLD;
      LK_HOLD:
        if (!lk_aligned)
          lk_state_d = LK_WAIT;
        else if (wr_ready && N > 1)
          lk_state_d = LK_FILL;
      default:
        lk_state_d = LK_WAIT;
    endcase
  end

  always_ff @(posedge link_speed_clock_i)
  begin
    if (!link_rst_n_i)
      lk_state_q <= LK_WAIT;
    else
      lk_state_q <= lk_state_d;
  end

  // slot pointer; a stalled buffer drops symbols rather than stall the lanes
  always_ff @(posedge link_speed_clock_i)
  begin
    if (!link_rst_n_i)
      slot_q <= '0;
    else if (lk_state_q == LK_WAIT || !lk_aligned)
      slot_q <= '0;
    else if (take)
      slot_q <= (slot_q == LAST_SLOT) ? '0 : slot_q + SEL_W'(1);
  end

  // slot storage, packed into one word per N pixels
  for (genvar g = 0; g < N; g++)
  begin : g_slot
    always_ff @(posedge link_speed_clock_i)
    begin
      if (!link_rst_n_i)
        slots_q[g] <= '0;
      else if (take && lk_aligned && slot_q == SEL_W'(g))
        slots_q[g] <= cur_pix;
    end
    assign wr_word[g*SLOT_W +: SLOT_W] = slots_q[g];
  end

  // ---------------- crossing ----------------
  logic              rd_valid;
  logic              rd_ready;
  logic [WORD_W-1:0] rd_word;
  logic              acq_s1_q;
  logic              acq_s2_q;

  vspo_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) i_vspo_fifo (
    .wr_clk_i   (link_speed_clock_i),
    .wr_rst_n_i (link_rst_n_i),
    .wr_valid_i (wr_valid),
    .wr_ready_o (wr_ready),
    .wr_data_i  (wr_word),
    .rd_clk_i   (clock_i),
    .rd_rst_n_i (rst_n_i),
    .rd_valid_o (rd_valid),
    .rd_ready_i (rd_ready),
    .rd_data_o  (rd_word)
  );

  // lock level into the pixel domain
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      acq_s1_q <= 1'b0;
      acq_s2_q <= 1'b0;
    end
    else
    begin
      acq_s1_q <= lk_aligned;
      acq_s2_q <= acq_s1_q;
    end
  end

  // ---------------- pixel domain ----------------
  logic             qualify;
  logic             vs_now;
  logic             vs_prev_q;
  logic             frame_start;
  logic [CNT_W-1:0] word_de;
  logic [CNT_W-1:0] len_q;
  logic [CNT_W-1:0] dur_q;
  logic [CNT_W-1:0] ref_len_q;
  logic [CNT_W-1:0] ref_dur_q;
  logic [1:0]       seen_q;
  logic [1:0]       match_q;
  logic [1:0]       miss_q;
  logic             same;
  logic             stable_q;
  vspo_pix_s        rd_pix [N];

  // popped word split back into slots, so field positions come from the struct
  for (genvar g = 0; g < N; g++)
  begin : g_rd_slot
    assign rd_pix[g] = rd_word[g*SLOT_W +: SLOT_W];
  end

  // words drain while unlocked so stale pixels never surface later
  assign rd_ready = !acq_s2_q || pixel_ready_i;
  assign qualify  = rd_valid && acq_s2_q && pixel_ready_i;

  // output slots registered from the popped word
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pixel_data_out_o    <= '0;
      active_video_flag_o <= '0;
      line_sync_out_o     <= '0;
      frame_sync_out_o    <= '0;
      pixel_qualifier_o   <= 1'b0;
    end
    else
    begin
      pixel_qualifier_o <= qualify;
      if (!acq_s2_q)
        active_video_flag_o <= '0;
      for (int i = 0; i < N; i++)
      begin
        if (qualify)
        begin
          pixel_data_out_o[i*PIX_W +: PIX_W] <= rd_pix[i].data;
          active_video_flag_o[i] <= rd_pix[i].de;
          line_sync_out_o[i]     <= rd_pix[i].hs;
          frame_sync_out_o[i]    <= rd_pix[i].vs;
        end
      end
    end
  end

  assign link_acquired_o = acq_s2_q;

  // per-word active count and frame edge
  always_comb
  begin
    word_de = '0;
    vs_now  = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      word_de = word_de + CNT_W'(rd_pix[i].de);
      vs_now  = vs_now | rd_pix[i].vs;
    end
  end

  assign frame_start = qualify && vs_now && !vs_prev_q;
  assign same        = (len_q == ref_len_q) && (dur_q == ref_dur_q);

  // active length in pixels and frame duration in words, over qualified words
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !acq_s2_q)
    begin
      vs_prev_q <= 1'b0;
      len_q     <= '0;
      dur_q     <= '0;
      ref_len_q <= '0;
      ref_dur_q <= '0;
      seen_q    <= '0;
    end
    else if (qualify)
    begin
      vs_prev_q <= vs_now;
      if (frame_start)
      begin
        len_q     <= word_de;
        dur_q     <= CNT_W'(1);
        ref_len_q <= len_q;
        ref_dur_q <= dur_q;
        seen_q    <= (seen_q == 2'h3) ? seen_q : seen_q + 2'h1;
      end
      else
      begin
        len_q <= len_q + word_de;
        dur_q <= dur_q + CNT_W'(1);
      end
    end
  end

  // agreement streaks; first partial frame never takes part
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !acq_s2_q)
    begin
      match_q  <= '0;
      miss_q   <= '0;
      stable_q <= 1'b0;
    end
    else if (frame_start && seen_q >= CMP_SEEN)
    begin
      if (same)
      begin
        match_q <= (match_q == STABLE_MATCHES) ? match_q : match_q + 2'h1;
        miss_q  <= '0;
        if (match_q + 2'h1 >= STABLE_MATCHES)
          stable_q <= 1'b1;
      end
      else
      begin
        miss_q  <= (miss_q == UNSTABLE_MISSES) ? miss_q : miss_q + 2'h1;
        match_q <= '0;
        if (miss_q + 2'h1 >= UNSTABLE_MISSES)
          stable_q <= 1'b0;
      end
    end
  end

  assign video_timing_stable_o = stable_q;

endmodule // vspo_top

//--- verif/vspo_assertions.sv
`timescale 1ns/1ns
module vspo_assertions
  import vspo_pkg::*;
#(
  parameter int unsigned N = PIX_PER_CLK
)(
  input wire logic               clock_i,
  input wire logic               rst_n_i,
  input wire logic               lanes_aligned_i,
  input wire logic               pixel_ready_i,
  input wire logic [N*PIX_W-1:0] pixel_data_out_o,
  input wire logic [N-1:0]       active_video_flag_o,
  input wire logic [N-1:0]       line_sync_out_o,
  input wire logic [N-1:0]       frame_sync_out_o,
  input wire logic               pixel_qualifier_o,
  input wire logic               link_acquired_o,
  input wire logic               video_timing_stable_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // one cycle of grace after loss, since the qualifier is registered
  acq_gate_a: assert property (!link_acquired_o && !$past(link_acquired_o) |->
    !pixel_qualifier_o && active_video_flag_o == '0 && !video_timing_stable_o)
    else $error("outputs active without link");
  qual_ready_a: assert property (pixel_qualifier_o |-> $past(pixel_ready_i))
    else $error("word given while stalled");
  qual_acq_a: assert property (pixel_qualifier_o |-> $past(link_acquired_o))
    else $error("word given before acquire");
  data_hold_a: assert property (!pixel_qualifier_o |->
    $stable(pixel_data_out_o) && $stable(line_sync_out_o) && $stable(frame_sync_out_o))
    else $error("outputs moved without qualifier");
  flag_hold_a: assert property (!pixel_qualifier_o && link_acquired_o &&
    $past(link_acquired_o) |-> $stable(active_video_flag_o))
    else $error("active flag moved without qualifier");
  acq_late_a: assert property ($rose(link_acquired_o) |->
    lanes_aligned_i && $past(lanes_aligned_i, 16))
    else $error("acquire too early");
  stable_rise_a: assert property ($rose(video_timing_stable_o) |->
    link_acquired_o && |frame_sync_out_o)
    else $error("stable set off a frame start");
  stable_fall_a: assert property ($fell(video_timing_stable_o) |->
    !link_acquired_o || !$past(link_acquired_o) || |frame_sync_out_o)
    else $error("stable cleared off a frame start");
endmodule // vspo_assertions

bind vspo_top vspo_assertions #(.N(N)) i_vspo_assertions (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .lanes_aligned_i(lanes_aligned_i),
  .pixel_ready_i(pixel_ready_i), .pixel_data_out_o(pixel_data_out_o),
  .active_video_flag_o(active_video_flag_o), .line_sync_out_o(line_sync_out_o),
  .frame_sync_out_o(frame_sync_out_o), .pixel_qualifier_o(pixel_qualifier_o),
  .link_acquired_o(link_acquired_o), .video_timing_stable_o(video_timing_stable_o));

//--- verif/vspo_lane_model.sv
`timescale 1ns/1ns
module vspo_lane_model
  import vspo_pkg::*;
(
  input  wire logic                               link_clk_i,
  input  wire logic                               run_i,
  input  wire logic                               four_i,
  input  wire logic                               glitch_i,
  output logic [NUM_LANES-1:0][LANE_W_FRL-1:0]   lanes_o
);
  logic [15:0] k_q = 16'h0;
  logic [2:0]  ctl;

  // pixel index; lanes cannot stall, so it runs on every edge while sending
  always_ff @(posedge link_clk_i)
  begin
    if (run_i)
      k_q <= k_q + 16'h1;
  end

  // lines of eight, frames of four lines; glitch shortens the active run
  assign ctl = {k_q[4:0] == 5'h0, k_q[2:0] == 3'h0,
                k_q[2:0] >= 3'h2 && !(glitch_i && k_q[2:0] == 3'h7)};

  // unused bits carry moving junk so that ignoring them is really tested
  assign lanes_o[0] = {4'hF, ~k_q, 1'b1, ctl, k_q};
  assign lanes_o[1] = {4'h0, k_q, 4'h9, k_q ^ 16'h3C3C};
  assign lanes_o[2] = {k_q, 8'h6E, ~k_q};
  assign lanes_o[3] = {k_q, 8'h1B, four_i ? k_q ^ 16'h5A5A : k_q ^ 16'hE1D2};
endmodule // vspo_lane_model

//--- verif/tb_vspo_top.sv
`timescale 1ns/1ns
module tb_vspo_top
  import vspo_pkg::*;
;
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, link_rst_n = 1'b0;
  logic aligned = 1'b0, mode = 1'b0, ready = 1'b1, glitch = 1'b0, four;
  logic [2:0] rate = 3'h1;
  logic [NUM_LANES-1:0][LANE_W_FRL-1:0] lanes;
  logic [2*PIX_W-1:0] data;
  logic [1:0] de, hs, vs;
  logic qual, acq, stable;
  int fail_count = 0, n_tests = 0, cycles = 0;
  // a drained burst must span at least half the buffer
  localparam int DEPTH_MIN = FIFO_DEPTH / 2;

  // pixel clock 8 ns; link clock 125 ns with an unrelated phase
  always #4 clk = ~clk;
  always
  begin
    #63 lclk = 1'b1;
    #62 lclk = 1'b0;
  end
  assign four = mode && rate >= 3'h3;

  vspo_top i_vspo_top (.clock_i(clk), .rst_n_i(rst_n), .link_speed_clock_i(lclk),
    .link_rst_n_i(link_rst_n), .lane_symbols_i(lanes), .lanes_aligned_i(aligned),
    .fixed_rate_mode_i(mode), .link_rate_i(rate), .pixel_ready_i(ready),
    .pixel_data_out_o(data), .active_video_flag_o(de), .line_sync_out_o(hs),
    .frame_sync_out_o(vs), .pixel_qualifier_o(qual), .link_acquired_o(acq),
    .video_timing_stable_o(stable));
  vspo_lane_model i_vspo_lane_model (.link_clk_i(lclk), .run_i(aligned), .four_i(four),
    .glitch_i(glitch), .lanes_o(lanes));

  task complete_run();
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      complete_run();
    end
  end

  task chk_b(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t flag mismatch", $time);
    end
  endtask

  task chk_v(input logic [PIX_W-1:0] got, input logic [PIX_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t pixel mismatch", $time);
    end
  endtask

  // pixel as the lane model spreads index k over three or four lanes
  function automatic logic [PIX_W-1:0] exp_pix(input logic [15:0] k);
    exp_pix = four ? {k[11:0] ^ 12'hA5A, ~k[11:0], k[11:0] ^ 12'hC3C, k[11:0]}
                   : {~k, k ^ 16'h3C3C, k};
  endfunction

  task wait_word();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end while (qual !== 1'b1 && i < 3000);
    if (i >= 3000)
      chk_b(1'b0, 1'b1);
  endtask

  // both domains reset, then lanes line up and the link must be acquired
  task start(input logic m, input logic [2:0] r);
    int i;
    @(posedge clk);
    aligned <= 1'b0;
    rst_n <= 1'b0;
    mode <= m;
    rate <= r;
    @(posedge lclk);
    link_rst_n <= 1'b0;
    repeat (3) @(posedge lclk);
    link_rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    aligned <= 1'b1;
    i = 0;
    while (acq !== 1'b1 && i < 300)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk_b(acq, 1'b1);
  endtask

  task check_words(input int n);
    logic [15:0] k, ks;
    repeat (n)
    begin
      wait_word();
      k = four ? {4'h0, data[11:0]} : data[15:0];
      for (int s = 0; s < 2; s++)
      begin
        ks = k + s;
        chk_v(data[s*PIX_W +: PIX_W], exp_pix(ks));
        chk_b(de[s], ks[2:0] >= 3'h2);
        chk_b(hs[s], ks[2:0] == 3'h0);
        chk_b(vs[s], ks[4:0] == 5'h0);
      end
    end
  endtask

  // every fixed-rate link rate, then minimized-transition mode
  task t_modes();
    for (int r = 1; r <= 6; r++)
    begin
      start(1'b1, r[2:0]);
      check_words(6);
    end
    start(1'b0, 3'h3);
    check_words(6);
  endtask

  // count frame starts up to stability, then break the active run
  task t_stable();
    int fs;
    start(1'b1, 3'h5);
    fs = 0;
    do
    begin
      wait_word();
      if (|vs)
        fs++;
    end while (stable !== 1'b1 && fs < 8);
    chk_b(fs == 4, 1'b1);
    @(posedge clk);
    glitch <= 1'b1;
    fs = 0;
    // flip the active run every frame so that neighbouring frames disagree
    do
    begin
      wait_word();
      if (|vs)
      begin
        fs++;
        if (stable === 1'b1)
          glitch <= ~glitch;
      end
    end while (stable !== 1'b0 && fs < 8);
    chk_b(fs >= 2 && fs <= 3, 1'b1);
    glitch <= 1'b0;
  endtask

  // regain stability, then lose alignment; all qualifiers must go quiet
  task t_loss();
    int i;
    i = 0;
    while (stable !== 1'b1 && i < 80)
    begin
      wait_word();
      i++;
    end
    chk_b(stable, 1'b1);
    aligned <= 1'b0;
    i = 0;
    while (acq !== 1'b0 && i < 300)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk_b(acq, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk_b(stable, 1'b0);
    chk_b(qual, 1'b0);
  endtask

  // stall until the buffer overflows, then expect a back-to-back drain
  task t_stall();
    int run;
    start(1'b1, 3'h4);
    wait_word();
    ready <= 1'b0;
    repeat (40) @(posedge lclk);
    @(posedge clk);
    ready <= 1'b1;
    wait_word();
    run = 1;
    while (run < 40)
    begin
      @(posedge clk);
      #1;
      if (qual !== 1'b1)
        break;
      run++;
    end
    chk_b(run >= DEPTH_MIN, 1'b1);
    check_words(4);
  endtask

  initial
  begin
    t_modes();
    t_stable();
    t_loss();
    t_stall();
    complete_run();
  end
endmodule // tb_vspo_top
